/* design/usbpo_pkg.sv */
package usbpo_pkg;

    localparam int unsigned REG_W          = 32;
    localparam int unsigned TSEL_W         = 4;

    localparam int unsigned BIT_TSEL_LO    = 16;
    localparam int unsigned BIT_TSEL_HI    = 19;
    localparam int unsigned BIT_OWNER      = 13;
    localparam int unsigned BIT_SUPPLY     = 12;
    localparam int unsigned BIT_LINE_DP    = 11;
    localparam int unsigned BIT_LINE_DM    = 10;

    localparam logic [3:0]  TSEL_NORMAL    = 4'h0;
    localparam logic [3:0]  TSEL_FORCE_J   = 4'h1;
    localparam logic [3:0]  TSEL_FORCE_K   = 4'h2;
    localparam logic [3:0]  TSEL_SE0_NAK   = 4'h3;
    localparam logic [3:0]  TSEL_PACKET    = 4'h4;
    localparam logic [3:0]  TSEL_FORCE_EN  = 4'h5;
    localparam logic [3:0]  TSEL_RSVD_LO   = 4'h6;

    localparam logic [3:0]  RST_TSEL       = 4'h0;
    localparam logic        RST_OWNER      = 1'h1;
    localparam logic        RST_SUPPLY     = 1'h0;
    localparam logic [1:0]  RST_LINE       = 2'h0;
    localparam logic [31:0] RST_READ       = 32'h0000_2000;
    localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

    typedef enum logic [2:0] {
        USBPO_MODE_NONE,
        USBPO_MODE_J,
        USBPO_MODE_K,
        USBPO_MODE_SE0_NAK,
        USBPO_MODE_PACKET,
        USBPO_MODE_FORCE_EN
    } usbpo_mode_e;

    function automatic logic usbpo_tsel_reserved(input logic [3:0] sel);
        usbpo_tsel_reserved = (sel >= TSEL_RSVD_LO);
    endfunction : usbpo_tsel_reserved

    function automatic usbpo_mode_e usbpo_tsel_decode(input logic [3:0] sel);
        usbpo_mode_e m;
        m = USBPO_MODE_NONE;
        unique case (sel)
            TSEL_FORCE_J:  m = USBPO_MODE_J;
            TSEL_FORCE_K:  m = USBPO_MODE_K;
            TSEL_SE0_NAK:  m = USBPO_MODE_SE0_NAK;
            TSEL_PACKET:   m = USBPO_MODE_PACKET;
            TSEL_FORCE_EN: m = USBPO_MODE_FORCE_EN;
            default:       m = USBPO_MODE_NONE;
        endcase
        usbpo_tsel_decode = m;
    endfunction : usbpo_tsel_decode

endpackage : usbpo_pkg

/* design/usbpo_port_owner.sv */
`timescale 1ns/1ns
// What this block does
// - Select zero normal, one J, two K
// - Select three SE0_NAK, four packet, five enable
// - Select six to fifteen reserved, no drive
// - Routing flag rising clears companion ownership
// - Routing flag low holds ownership at one
// - Ownership one means companion controls port
// - No switch capability: supply reads one from the first clock after reset
// - Switch capable: supply bit drives switch
// - Unpowered port nonfunctional, reports no changes
// - Overcurrent on powered switch-capable port cuts supply
// - Snapshot bit 11 is D+, 10 D-
// - Unpowered port snapshot carries no value
module usbpo_port_owner
    import usbpo_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     reset_n,
    input  wire logic                     reg_wr,
    input  wire logic [usbpo_pkg::REG_W-1:0] reg_wdata,
    output logic      [usbpo_pkg::REG_W-1:0] port_status_control,
    input  wire logic                     routing_config_flag,
    input  wire logic                     power_switch_capable,
    input  wire logic                     overcurrent,
    input  wire logic                     line_dp,
    input  wire logic                     line_dm,
    input  wire logic                     status_change_in,
    output logic                          status_change_out,
    output logic                          companion_ownership,
    output logic                          port_supply_switch,
    output logic                          force_j,
    output logic                          force_k,
    output logic                          se0_nak,
    output logic                          test_packet,
    output logic                          force_enable
);
    import usbpo_pkg::*;

    typedef struct packed {
        logic [3:0]  tsel;
        logic        owner;
        logic        supply;
        logic        cf_prev;
        logic [1:0]  line;
        logic        change;
        logic [31:0] rdata;
    } usbpo_state_s;

    usbpo_state_s state_q;
    usbpo_state_s state_d;

    usbpo_test_if tst ();

    usbpo_test_decode u_test_decode (
        .clock   (clock),
        .reset_n (reset_n),
        .tst     (tst.decoder)
    );

    // Test drive only while we own a powered port
    assign tst.select = state_q.tsel;
    assign tst.enable = state_q.supply && !state_q.owner;

    always_comb begin
        state_d = state_q;

        if (reg_wr) begin
            // Reserved codes are stored as written; the decoder ignores them
            state_d.tsel = reg_wdata[BIT_TSEL_HI:BIT_TSEL_LO];
        end

        // Flag edge beats a same-cycle software write
        state_d.cf_prev = routing_config_flag;
        if (!routing_config_flag) begin
            state_d.owner = 1'b1;
        end else if (!state_q.cf_prev) begin
            state_d.owner = 1'b0;
        end else if (reg_wr) begin
            state_d.owner = reg_wdata[BIT_OWNER];
        end

        // Overcurrent on a powered switch-capable port wins over a same-cycle write, so the port turns off
        if (!power_switch_capable) begin
            state_d.supply = 1'b1;
        end else if (overcurrent && state_q.supply) begin
            state_d.supply = 1'b0;
        end else if (reg_wr) begin
            state_d.supply = reg_wdata[BIT_SUPPLY];
        end

        // Lines are only meaningful with supply on
        state_d.line   = state_q.supply ? {line_dp, line_dm} : RST_LINE;
        state_d.change = status_change_in && state_q.supply;

        state_d.rdata = ZERO_WORD;
        state_d.rdata[BIT_TSEL_HI:BIT_TSEL_LO] = state_d.tsel;
        state_d.rdata[BIT_OWNER]   = state_d.owner;
        state_d.rdata[BIT_SUPPLY]  = state_d.supply;
        state_d.rdata[BIT_LINE_DP] = state_d.line[1];
        state_d.rdata[BIT_LINE_DM] = state_d.line[0];
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q.tsel    <= RST_TSEL;
            state_q.owner   <= RST_OWNER;
            state_q.supply  <= RST_SUPPLY;
            state_q.cf_prev <= 1'b0;
            state_q.line    <= RST_LINE;
            state_q.change  <= 1'b0;
            state_q.rdata   <= RST_READ;
        end else begin
            state_q <= state_d;
        end
    end

    assign port_status_control = state_q.rdata;
    assign companion_ownership = state_q.owner;
    assign port_supply_switch  = state_q.supply;
    assign status_change_out   = state_q.change;
    assign force_j             = tst.force_j;
    assign force_k             = tst.force_k;
    assign se0_nak             = tst.se0_nak;
    assign test_packet         = tst.test_packet;
    assign force_enable        = tst.force_enable;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    logic [3:0] rd_tsel;
    logic       drive_ok;
    assign rd_tsel  = port_status_control[BIT_TSEL_HI:BIT_TSEL_LO];
    assign drive_ok = port_supply_switch && !companion_ownership;

    sequence s_cf_rise;
        !routing_config_flag ##1 routing_config_flag;
    endsequence

    sequence s_sel_ready(logic [3:0] code);
        rd_tsel == code && drive_ok;
    endsequence

    sequence s_oc_on_powered;
        power_switch_capable && port_supply_switch && overcurrent;
    endsequence

    property p_mode_follows(logic [3:0] code, logic out);
        s_sel_ready(code) |=> out;
    endproperty

    owner_clear_a: assert property (
        s_cf_rise |=> !companion_ownership
    ) else $error("ownership not cleared after routing flag rose");

    owner_hold_a: assert property (
        !routing_config_flag |=> companion_ownership && port_status_control[BIT_OWNER]
    ) else $error("ownership not held while routing flag low");

    owner_write_a: assert property (
        routing_config_flag && $past(routing_config_flag) && reg_wr
        |=> companion_ownership == $past(reg_wdata[BIT_OWNER])
    ) else $error("ownership write not taken");

    owner_quiet_a: assert property (
        companion_ownership |=> !(force_j || force_k || se0_nak || test_packet || force_enable)
    ) else $error("test drive while companion owns port");

    mode_j_a: assert property (
        p_mode_follows(TSEL_FORCE_J, force_j)
    ) else $error("force J not driven");

    mode_k_a: assert property (
        p_mode_follows(TSEL_FORCE_K, force_k)
    ) else $error("force K not driven");

    mode_se0_a: assert property (
        p_mode_follows(TSEL_SE0_NAK, se0_nak)
    ) else $error("SE0_NAK not driven");

    mode_pkt_a: assert property (
        p_mode_follows(TSEL_PACKET, test_packet)
    ) else $error("test packet not driven");

    mode_fen_a: assert property (
        p_mode_follows(TSEL_FORCE_EN, force_enable)
    ) else $error("force enable not driven");

    mode_rsvd_a: assert property (
        usbpo_tsel_reserved(rd_tsel) || rd_tsel == TSEL_NORMAL
        |=> !(force_j || force_k || se0_nak || test_packet || force_enable)
    ) else $error("drive on normal or reserved select");

    supply_fixed_a: assert property (
        !power_switch_capable |=> port_supply_switch && port_status_control[BIT_SUPPLY]
    ) else $error("supply not on without switch");

    supply_write_a: assert property (
        power_switch_capable && reg_wr && !(overcurrent && port_supply_switch)
        |=> port_supply_switch == $past(reg_wdata[BIT_SUPPLY])
    ) else $error("supply write not taken");

    supply_cut_a: assert property (
        s_oc_on_powered |=> !port_supply_switch
    ) else $error("overcurrent did not cut supply");

    change_gate_a: assert property (
        !port_supply_switch |=> !status_change_out
    ) else $error("status change reported while unpowered");

    change_pass_a: assert property (
        port_supply_switch && status_change_in |=> status_change_out
    ) else $error("status change lost while powered");

    line_snap_a: assert property (
        port_supply_switch |=> port_status_control[BIT_LINE_DP:BIT_LINE_DM]
                               == $past({line_dp, line_dm})
    ) else $error("line snapshot does not follow lines");

    // Reverse checks: a drive may only come from a selected, owned, powered port
    logic [4:0] drive_vec;
    assign drive_vec = {force_j, force_k, se0_nak, test_packet, force_enable};

    drive_one_a: assert property (
        $onehot0(drive_vec)
    ) else $error("more than one test drive at once");

    src_j_a: assert property (
        force_j
        |-> $past(rd_tsel == TSEL_FORCE_J && drive_ok)
    ) else $error("force J without its select");

    src_k_a: assert property (
        force_k
        |-> $past(rd_tsel == TSEL_FORCE_K && drive_ok)
    ) else $error("force K without its select");

    src_se0_a: assert property (
        se0_nak
        |-> $past(rd_tsel == TSEL_SE0_NAK && drive_ok)
    ) else $error("SE0_NAK without its select");

    src_pkt_a: assert property (
        test_packet
        |-> $past(rd_tsel == TSEL_PACKET && drive_ok)
    ) else $error("test packet without its select");

    src_fen_a: assert property (
        force_enable
        |-> $past(rd_tsel == TSEL_FORCE_EN && drive_ok)
    ) else $error("force enable without its select");

    // Reserved codes must read back so software sees what it wrote
    tsel_store_a: assert property (
        reg_wr
        |=> rd_tsel == $past(reg_wdata[BIT_TSEL_HI:BIT_TSEL_LO])
    ) else $error("test select not stored");

    owner_cfwin_a: assert property (
        s_cf_rise ##0 reg_wr
        |=> !companion_ownership
    ) else $error("write beat routing flag rise");

    owner_rd_a: assert property (
        port_status_control[BIT_OWNER] == companion_ownership
    ) else $error("ownership image differs from output");

    supply_rd_a: assert property (
        port_status_control[BIT_SUPPLY] == port_supply_switch
    ) else $error("supply image differs from switch");

    supply_ocwin_a: assert property (
        s_oc_on_powered ##0 reg_wr
        |=> !port_supply_switch
    ) else $error("write beat overcurrent cut");

    unpowered_quiet_a: assert property (
        !port_supply_switch
        |=> drive_vec == 5'h00
    ) else $error("test drive on unpowered port");

    line_off_a: assert property (
        !port_supply_switch
        |=> port_status_control[BIT_LINE_DP:BIT_LINE_DM] == RST_LINE
    ) else $error("snapshot not cleared while unpowered");

endmodule : usbpo_port_owner

/* design/usbpo_test_decode.sv */
`timescale 1ns/1ns
module usbpo_test_decode
    import usbpo_pkg::*;
(
    input  wire logic     clock,
    input  wire logic     reset_n,
    usbpo_test_if.decoder tst
);
    import usbpo_pkg::*;

    typedef struct packed {
        logic force_j;
        logic force_k;
        logic se0_nak;
        logic test_packet;
        logic force_enable;
    } usbpo_tdec_s;

    usbpo_tdec_s state_q;
    usbpo_tdec_s state_d;
    usbpo_mode_e mode;

    always_comb begin
        state_d = '0;
        // Reserved codes fall to no drive at all
        mode    = tst.enable ? usbpo_tsel_decode(tst.select) : USBPO_MODE_NONE;
        unique case (mode)
            USBPO_MODE_NONE:     state_d = '0;
            USBPO_MODE_J:        state_d.force_j      = 1'b1;
            USBPO_MODE_K:        state_d.force_k      = 1'b1;
            USBPO_MODE_SE0_NAK:  state_d.se0_nak      = 1'b1;
            USBPO_MODE_PACKET:   state_d.test_packet  = 1'b1;
            USBPO_MODE_FORCE_EN: state_d.force_enable = 1'b1;
            default:             state_d = '0;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign tst.force_j      = state_q.force_j;
    assign tst.force_k      = state_q.force_k;
    assign tst.se0_nak      = state_q.se0_nak;
    assign tst.test_packet  = state_q.test_packet;
    assign tst.force_enable = state_q.force_enable;

endmodule : usbpo_test_decode

/* design/usbpo_test_if.sv */
`timescale 1ns/1ns
interface usbpo_test_if;
    logic [3:0] select;
    logic       enable;
    logic       force_j;
    logic       force_k;
    logic       se0_nak;
    logic       test_packet;
    logic       force_enable;

    modport decoder (
        input  select,
        input  enable,
        output force_j,
        output force_k,
        output se0_nak,
        output test_packet,
        output force_enable
    );

    modport owner (
        output select,
        output enable,
        input  force_j,
        input  force_k,
        input  se0_nak,
        input  test_packet,
        input  force_enable
    );
endinterface : usbpo_test_if

/* verif/usb_port_owner_power_line_status_tb.sv */
`timescale 1ns/1ns
module usb_port_owner_power_line_status_tb;
    import usbpo_pkg::*;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic        reg_wr = 1'b0;
    logic [31:0] reg_wdata = ZERO_WORD;
    logic [31:0] psc;
    logic        flag = 1'b0;
    logic        capable = 1'b0;
    logic        oc = 1'b0;
    logic        sci = 1'b0;
    logic        sco;
    logic        own;
    logic        supply;
    logic        dp;
    logic        dm;
    logic [1:0]  line_state = 2'h0;
    wire  [4:0]  drv;
    int          failures = 0;
    int          n_tests = 0;

    always #4 clock = ~clock;

    usbpo_port_owner DUT (
        .clock                (clock),
        .reset_n              (reset_n),
        .reg_wr               (reg_wr),
        .reg_wdata            (reg_wdata),
        .port_status_control  (psc),
        .routing_config_flag  (flag),
        .power_switch_capable (capable),
        .overcurrent          (oc),
        .line_dp              (dp),
        .line_dm              (dm),
        .status_change_in     (sci),
        .status_change_out    (sco),
        .companion_ownership  (own),
        .port_supply_switch   (supply),
        .force_j              (drv[4]),
        .force_k              (drv[3]),
        .se0_nak              (drv[2]),
        .test_packet          (drv[1]),
        .force_enable         (drv[0])
    );

    usbpo_dev_model u_dev (
        .powered    (supply),
        .line_state (line_state),
        .line_dp    (dp),
        .line_dm    (dm)
    );

    task automatic give_verdict();
        $display("tests %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    function automatic logic [31:0] psc_word(input logic [3:0] sel, input logic ob, input logic sb);
        psc_word = {12'h000, sel, 2'h0, ob, sb, 12'h000};
    endfunction : psc_word

    // One-hot order: J, K, SE0_NAK, packet, force enable
    function automatic logic [4:0] exp_drive(input logic [3:0] sel);
        case (sel)
            4'h1:    exp_drive = 5'h10;
            4'h2:    exp_drive = 5'h08;
            4'h3:    exp_drive = 5'h04;
            4'h4:    exp_drive = 5'h02;
            4'h5:    exp_drive = 5'h01;
            default: exp_drive = 5'h00;
        endcase
    endfunction : exp_drive

    // Taken at the second edge; image is checked at the following falling edge
    task automatic wr(input logic [31:0] data);
        @(posedge clock);
        reg_wr    <= 1'h1;
        reg_wdata <= data;
        @(posedge clock);
        reg_wr    <= 1'h0;
        @(negedge clock);
    endtask : wr

    task automatic do_reset();
        @(posedge clock);
        reset_n <= 1'h0;
        @(posedge clock);
        @(negedge clock);
        check("reset image", RST_READ, psc);
        check("reset owner", 32'h1, own);
        check("reset supply", 32'h0, supply);
        check("reset drives", 32'h0, drv);
        @(posedge clock);
        reset_n <= 1'h1;
    endtask : do_reset

    task automatic t_start();
        @(posedge clock);
        @(negedge clock);
        check("start image", psc_word(4'h0, 1'h1, 1'h1), psc);
        wr(psc_word(4'h0, 1'h0, 1'h0));
        check("fixed supply", 32'h1, supply);
        check("held owner", 32'h1, own);
        $display("test start done");
    endtask : t_start

    task automatic t_supply();
        @(posedge clock);
        capable <= 1'h1;
        wr(psc_word(4'h0, 1'h1, 1'h0));
        check("supply off", psc_word(4'h0, 1'h1, 1'h0), psc);
        wr(psc_word(4'h0, 1'h1, 1'h1));
        check("supply on", 32'h1, supply);
        @(posedge clock);
        oc <= 1'h1;
        @(posedge clock);
        oc <= 1'h0;
        @(negedge clock);
        check("overcurrent cut", 32'h0, supply);
        wr(psc_word(4'h0, 1'h1, 1'h1));
        check("supply back", 32'h1, supply);
        $display("test supply done");
    endtask : t_supply

    task automatic t_owner();
        @(posedge clock);
        flag <= 1'h1;
        @(posedge clock);
        @(negedge clock);
        check("flag rise owner", 32'h0, own);
        wr(psc_word(4'h0, 1'h1, 1'h1));
        check("owner handed", 32'h1, own);
        wr(psc_word(4'h0, 1'h0, 1'h1));
        check("owner taken", 32'h0, own);
        @(posedge clock);
        flag <= 1'h0;
        @(posedge clock);
        @(negedge clock);
        check("flag low owner", 32'h1, own);
        @(posedge clock);
        flag <= 1'h1;
        @(posedge clock);
        @(negedge clock);
        check("flag rise again", 32'h0, own);
        $display("test owner done");
    endtask : t_owner

    task automatic t_drive();
        for (int i = 0; i < 16; i++) begin
            wr(psc_word(i[3:0], 1'h0, 1'h1));
            check("select readback", i, psc[19:16]);
            @(negedge clock);
            check("test drive", exp_drive(i[3:0]), drv);
            @(negedge clock);
            check("drive stands", exp_drive(i[3:0]), drv);
        end
        wr(psc_word(4'h1, 1'h1, 1'h1));
        @(negedge clock);
        check("companion quiet", 32'h0, drv);
        wr(psc_word(4'h1, 1'h0, 1'h0));
        @(negedge clock);
        check("unpowered quiet", 32'h0, drv);
        wr(psc_word(4'h0, 1'h0, 1'h1));
        $display("test drive done");
    endtask : t_drive

    task automatic t_line();
        for (int v = 0; v < 4; v++) begin
            @(posedge clock);
            line_state <= v[1:0];
            @(posedge clock);
            @(negedge clock);
            check("line snapshot", v, psc[11:10]);
            if (v == 1) begin
                wr(psc_word(4'h0, 1'h1, 1'h1));
                check("low speed released", 32'h1, own);
                wr(psc_word(4'h0, 1'h0, 1'h1));
            end else begin
                check("kept for port reset", 32'h0, own);
            end
        end
        wr(psc_word(4'h0, 1'h0, 1'h0));
        @(negedge clock);
        check("unpowered snapshot", 32'h0, psc[11:10]);
        check("unpowered lines", 32'h0, {dp, dm});
        wr(psc_word(4'h0, 1'h0, 1'h1));
        $display("test line done");
    endtask : t_line

    task automatic t_change();
        for (int p = 1; p >= 0; p--) begin
            wr(psc_word(4'h0, 1'h0, p[0]));
            @(posedge clock);
            sci <= 1'h1;
            @(posedge clock);
            sci <= 1'h0;
            @(negedge clock);
            check("change reported", p, sco);
            @(negedge clock);
            check("change one cycle", 32'h0, sco);
        end
        $display("test change done");
    endtask : t_change

    task automatic t_midreset();
        do_reset();
        @(posedge clock);
        @(negedge clock);
        check("reset flag high owner", 32'h0, own);
        check("reset supply off", 32'h0, supply);
        check("reset image after", 32'h0, psc);
        $display("test midreset done");
    endtask : t_midreset

    initial begin
        do_reset();
        t_start();
        t_supply();
        t_owner();
        t_drive();
        t_line();
        t_change();
        t_midreset();
        give_verdict();
    end

    // Whole run needs under two hundred cycles; this is ample margin
    initial begin
        #16000;
        failures++;
        give_verdict();
    end
endmodule : usb_port_owner_power_line_status_tb

/* verif/usbpo_dev_model.sv */
`timescale 1ns/1ns
module usbpo_dev_model (
    input  wire logic       powered,
    input  wire logic [1:0] line_state,
    output logic            line_dp,
    output logic            line_dm
);
    // Unpowered port: host pull-downs win, lines sit at SE0
    assign line_dp = powered ? line_state[1] : 1'b0;
    assign line_dm = powered ? line_state[0] : 1'b0;
endmodule : usbpo_dev_model
